// >>> common/lscd_pkg.sv
// Purpose: shared constants and types of the link switch configuration decoder
// Assumes: 40 MHz system clock, configuration link at 10 Mbit/s
// Notes: one bit period is a whole number of clock cycles
package lscd_pkg;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 25;
    localparam int BIT_TIME_NS = 100;
    localparam int BIT_CYCLES = BIT_TIME_NS / CLK_PERIOD_NS;
    localparam int HALF_CYCLES = BIT_CYCLES / 2;
    localparam logic [3:0] BIT_RELOAD = 4'(BIT_CYCLES - 1);
    // first sample lands mid-way through the bit after the start bit
    localparam logic [3:0] FIRST_SAMPLE = 4'(BIT_CYCLES + HALF_CYCLES - 1);

    // ****************************************************************
    // framing and switch size
    // ****************************************************************
    localparam logic [3:0] DATA_FRAME_BITS = 4'hB;
    localparam logic [3:0] ACK_FRAME_BITS = 4'h2;
    localparam logic [2:0] LAST_DATA_BIT = 3'h7;
    localparam int NUM_LINKS = 32;
    localparam int LINK_W = 5;

    // ****************************************************************
    // command codes
    // ****************************************************************
    localparam logic [7:0] CMD_CONNECT = 8'h00;
    localparam logic [7:0] CMD_JOIN = 8'h01;
    localparam logic [7:0] CMD_QUERY = 8'h02;
    localparam logic [7:0] CMD_COMMIT = 8'h03;
    localparam logic [7:0] CMD_SOFTRST = 8'h04;
    localparam logic [7:0] NO_INPUT = 8'hFF;

    typedef enum logic [1:0] {
        RX_IDLE = 2'h0,
        RX_FLAG = 2'h1,
        RX_DATA = 2'h3,
        RX_STOP = 2'h2
    } lscd_rx_t;

    typedef enum logic [2:0] {
        DEC_CMD = 3'h0,
        DEC_PAR1 = 3'h1,
        DEC_PAR2 = 3'h3,
        DEC_EXEC = 3'h2,
        DEC_READ = 3'h6,
        DEC_REPLY = 3'h7
    } lscd_dec_t;

endpackage : lscd_pkg

// >>> hdl/lscd_route_mem.sv
// Purpose: routing table, one entry per switch output
// Assumes: single clock, registered read data
// Notes: table contents ignore rst_n; only the clear command empties them
`timescale 1ns/1ps
module lscd_route_mem (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // update side
    input wire logic wrEn,
    input wire logic [lscd_pkg::LINK_W-1:0] wrAddr,
    input wire logic [lscd_pkg::LINK_W-1:0] wrInput,
    input wire logic commit,
    input wire logic clearAll,
    // query port
    input wire logic [lscd_pkg::LINK_W-1:0] qAddr,
    output logic [lscd_pkg::LINK_W-1:0] qInput,
    output logic qConnected,
    // crossbar lookup port
    input wire logic [lscd_pkg::LINK_W-1:0] lkAddr,
    output logic [lscd_pkg::LINK_W-1:0] lkInput,
    output logic lkConnected,
    output logic lkActive
);
    import lscd_pkg::*;

    typedef struct packed {
        logic [LINK_W-1:0] qIn;
        logic qConn;
        logic [LINK_W-1:0] lkIn;
        logic lkConn;
        logic lkAct;
    } lscd_mem_rd_t;

    logic [LINK_W-1:0] inputNum [NUM_LINKS];
    logic [NUM_LINKS-1:0] connVec;
    logic [NUM_LINKS-1:0] activeVec;
    lscd_mem_rd_t rd_r;
    lscd_mem_rd_t rd_nxt;

    always_ff @(posedge clock) begin
        if (wrEn) begin
            inputNum[wrAddr] <= wrInput;
        end
    end

    always_ff @(posedge clock) begin
        if (clearAll) begin
            connVec <= '0;
            activeVec <= '0;
        end else if (commit) begin
            activeVec <= connVec;
        end else if (wrEn) begin
            connVec[wrAddr] <= 1'b1;
            activeVec[wrAddr] <= 1'b0;
        end
    end

    always_comb begin
        rd_nxt.qIn = inputNum[qAddr];
        rd_nxt.qConn = connVec[qAddr];
        rd_nxt.lkIn = inputNum[lkAddr];
        rd_nxt.lkConn = connVec[lkAddr];
        rd_nxt.lkAct = activeVec[lkAddr];
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_r <= '0;
        end else begin
            rd_r <= rd_nxt;
        end
    end

    assign qInput = rd_r.qIn;
    assign qConnected = rd_r.qConn;
    assign lkInput = rd_r.lkIn;
    assign lkConnected = rd_r.lkConn;
    assign lkActive = rd_r.lkAct;

endmodule : lscd_route_mem

// >>> hdl/lscd_decoder.sv
// Purpose: serial configuration link front end and command decoder of a link switch
// Assumes: one 40 MHz clock; crossbar outside reads routes through the lookup port
// Notes: disconnected outputs are to be driven low by the crossbar
`timescale 1ns/1ps
// Overview of operation
// - code 0: route input to output
// - code 1: join two links both ways
// - code 2: reply input routed to that output
// - code 3 commits; routes active after it
// - code 4: clear all routes, outputs low
// - hardware reset keeps existing routes
// - frame: high, one, 8 bits lsb-first, low
// - ack every byte; await ack before next
module lscd_decoder (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // configuration link
    input wire logic linkIn,
    output logic linkOut,
    // crossbar lookup
    input wire logic [lscd_pkg::LINK_W-1:0] xbarOutSel,
    output logic [lscd_pkg::LINK_W-1:0] xbarInSel,
    output logic xbarConnected,
    output logic xbarActive
);
    import lscd_pkg::*;

    typedef struct packed {
        logic sync1;
        logic sync2;
        lscd_rx_t rxSt;
        logic [3:0] rxCnt;
        logic [2:0] rxBit;
        logic [7:0] rxByte;
        logic byteValid;
        logic ackSeen;
        logic [10:0] txShift;
        logic [3:0] txBits;
        logic [3:0] txCnt;
        logic ackPend;
        logic awaitAck;
        lscd_dec_t dec;
        logic [7:0] cmd;
        logic [7:0] par;
        logic wrEn;
        logic [LINK_W-1:0] wrAddr;
        logic [LINK_W-1:0] wrInput;
        logic commit;
        logic clearAll;
    } lscd_state_t;

    lscd_state_t s_r;
    lscd_state_t s_nxt;
    logic [LINK_W-1:0] qInput;
    logic qConnected;
    logic [7:0] replyByte;
    logic replyGo;
    logic ackGo;

    function automatic logic isLink(input logic [7:0] b);
        return b < 8'(NUM_LINKS);
    endfunction : isLink

    function automatic logic [7:0] revByte(input logic [7:0] b);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) begin
            r[i] = b[7 - i];
        end
        return r;
    endfunction : revByte

    assign replyByte = qConnected ? {3'h0, qInput} : NO_INPUT;
    assign replyGo = (s_r.dec == DEC_REPLY) && (s_r.txBits == 4'h0) && !s_r.awaitAck;
    // holding the ack during a query stops the controller sending over the reply
    assign ackGo = s_r.ackPend && (s_r.txBits == 4'h0)
        && (s_r.dec != DEC_READ) && (s_r.dec != DEC_REPLY);

    always_comb begin
        s_nxt = s_r;
        s_nxt.sync1 = linkIn;
        s_nxt.sync2 = s_r.sync1;
        s_nxt.byteValid = 1'b0;
        s_nxt.ackSeen = 1'b0;
        s_nxt.wrEn = 1'b0;
        s_nxt.commit = 1'b0;
        s_nxt.clearAll = 1'b0;

        // ************************************************************
        // receiver
        // ************************************************************
        if (s_r.rxSt == RX_IDLE) begin
            if (s_r.sync2) begin
                s_nxt.rxCnt = FIRST_SAMPLE;
                s_nxt.rxSt = RX_FLAG;
            end
        end else if (s_r.rxCnt != 4'h0) begin
            s_nxt.rxCnt = s_r.rxCnt - 4'h1;
        end else begin
            s_nxt.rxCnt = BIT_RELOAD;
            unique case (s_r.rxSt)
                // one means data, zero means ack
                RX_FLAG: begin
                    if (s_r.sync2) begin
                        s_nxt.rxBit = 3'h0;
                        s_nxt.rxSt = RX_DATA;
                    end else begin
                        s_nxt.ackSeen = 1'b1;
                        s_nxt.rxSt = RX_IDLE;
                    end
                end
                RX_DATA: begin
                    s_nxt.rxByte = {s_r.sync2, s_r.rxByte[7:1]};
                    s_nxt.rxBit = s_r.rxBit + 3'h1;
                    if (s_r.rxBit == LAST_DATA_BIT) begin
                        s_nxt.rxSt = RX_STOP;
                    end
                end
                RX_STOP: begin
                    // a high stop bit is a broken frame: drop it and wait for idle
                    if (!s_r.sync2) begin
                        s_nxt.byteValid = (s_r.rxBit == 3'h0);
                        s_nxt.rxSt = RX_IDLE;
                    end else begin
                        // marks the frame as broken until the line falls
                        s_nxt.rxBit = 3'h1;
                    end
                end
                default: begin
                    s_nxt.rxSt = RX_IDLE;
                end
            endcase
        end

        // ************************************************************
        // transmitter
        // ************************************************************
        // clear first so that a reply load in the same cycle wins
        if (s_r.ackSeen) begin
            s_nxt.awaitAck = 1'b0;
        end
        if (s_r.txBits != 4'h0) begin
            if (s_r.txCnt != 4'h0) begin
                s_nxt.txCnt = s_r.txCnt - 4'h1;
            end else begin
                s_nxt.txShift = {s_r.txShift[9:0], 1'b0};
                s_nxt.txBits = s_r.txBits - 4'h1;
                s_nxt.txCnt = BIT_RELOAD;
            end
        end else if (ackGo) begin
            s_nxt.txShift = {2'b10, 9'h000};
            s_nxt.txBits = ACK_FRAME_BITS;
            s_nxt.txCnt = BIT_RELOAD;
            s_nxt.ackPend = 1'b0;
        end else if (replyGo) begin
            s_nxt.txShift = {2'b11, revByte(replyByte), 1'b0};
            s_nxt.txBits = DATA_FRAME_BITS;
            s_nxt.txCnt = BIT_RELOAD;
            s_nxt.awaitAck = 1'b1;
        end
        if (s_r.byteValid) begin
            s_nxt.ackPend = 1'b1;
        end

        // ************************************************************
        // command decoder
        // ************************************************************
        unique case (s_r.dec)
            DEC_CMD: begin
                if (s_r.byteValid) begin
                    s_nxt.cmd = s_r.rxByte;
                    if (s_r.rxByte == CMD_CONNECT || s_r.rxByte == CMD_JOIN
                        || s_r.rxByte == CMD_QUERY) begin
                        s_nxt.dec = DEC_PAR1;
                    end
                    s_nxt.commit = (s_r.rxByte == CMD_COMMIT);
                    s_nxt.clearAll = (s_r.rxByte == CMD_SOFTRST);
                end
            end
            DEC_PAR1: begin
                if (s_r.byteValid) begin
                    s_nxt.par = s_r.rxByte;
                    if (!isLink(s_r.rxByte)) begin
                        s_nxt.dec = DEC_CMD;
                    end else if (s_r.cmd == CMD_QUERY) begin
                        s_nxt.dec = DEC_READ;
                    end else begin
                        s_nxt.dec = DEC_PAR2;
                    end
                end
            end
            DEC_PAR2: begin
                if (s_r.byteValid) begin
                    s_nxt.dec = DEC_CMD;
                    if (isLink(s_r.rxByte)) begin
                        s_nxt.wrEn = 1'b1;
                        s_nxt.wrAddr = s_r.rxByte[LINK_W-1:0];
                        s_nxt.wrInput = s_r.par[LINK_W-1:0];
                        s_nxt.par = s_r.rxByte;
                        if (s_r.cmd == CMD_JOIN) begin
                            s_nxt.dec = DEC_EXEC;
                        end
                    end
                end
            end
            DEC_EXEC: begin
                s_nxt.wrEn = 1'b1;
                s_nxt.wrAddr = s_r.wrInput;
                s_nxt.wrInput = s_r.wrAddr;
                s_nxt.dec = DEC_CMD;
            end
            DEC_READ: begin
                s_nxt.dec = DEC_REPLY;
            end
            DEC_REPLY: begin
                if (replyGo) begin
                    s_nxt.dec = DEC_CMD;
                end
            end
            default: begin
                s_nxt.dec = DEC_CMD;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign linkOut = s_r.txShift[10];

    // ****************************************************************
    // routing table
    // ****************************************************************
    lscd_route_mem u_mem (
        .clock(clock),
        .rst_n(rst_n),
        .wrEn(s_r.wrEn),
        .wrAddr(s_r.wrAddr),
        .wrInput(s_r.wrInput),
        .commit(s_r.commit),
        .clearAll(s_r.clearAll),
        .qAddr(s_r.par[LINK_W-1:0]),
        .qInput(qInput),
        .qConnected(qConnected),
        .lkAddr(xbarOutSel),
        .lkInput(xbarInSel),
        .lkConnected(xbarConnected),
        .lkActive(xbarActive)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_connect;
        @(posedge clock) disable iff (!rst_n)
        s_r.byteValid && s_r.dec == DEC_PAR2 && s_r.cmd == CMD_CONNECT && isLink(s_r.rxByte)
        |=> s_r.wrEn && s_r.wrAddr == $past(s_r.rxByte[LINK_W-1:0])
            && s_r.wrInput == $past(s_r.par[LINK_W-1:0]) ##1 !s_r.wrEn;
    endproperty
    a_connect: assert property (p_connect) else $error("connect write wrong");

    property p_join;
        @(posedge clock) disable iff (!rst_n)
        s_r.byteValid && s_r.dec == DEC_PAR2 && s_r.cmd == CMD_JOIN && isLink(s_r.rxByte)
        |=> s_r.wrEn ##1 s_r.wrEn && s_r.wrAddr == $past(s_r.par[LINK_W-1:0], 2)
            && s_r.wrInput == $past(s_r.rxByte[LINK_W-1:0], 2);
    endproperty
    a_join: assert property (p_join) else $error("join second write wrong");

    property p_reply;
        @(posedge clock) disable iff (!rst_n)
        replyGo |=> s_r.txBits == DATA_FRAME_BITS && linkOut
            && s_r.txShift[8:1] == revByte($past(replyByte)) && s_r.awaitAck;
    endproperty
    a_reply: assert property (p_reply) else $error("query reply frame wrong");

    property p_commit;
        @(posedge clock) disable iff (!rst_n)
        s_r.byteValid && s_r.dec == DEC_CMD && s_r.rxByte == CMD_COMMIT
        |=> s_r.commit ##1 !s_r.commit;
    endproperty
    a_commit: assert property (p_commit) else $error("commit not issued");

    property p_softrst;
        @(posedge clock) disable iff (!rst_n)
        s_r.clearAll |=> ##1 !xbarConnected && !xbarActive;
    endproperty
    a_softrst: assert property (p_softrst) else $error("soft reset left a route");

    property p_idle_low;
        @(posedge clock) disable iff (!rst_n)
        s_r.txBits == 4'h0 |-> !linkOut;
    endproperty
    a_idle_low: assert property (p_idle_low) else $error("link not low when idle");

    property p_ack;
        @(posedge clock) disable iff (!rst_n)
        s_r.byteValid && s_r.dec != DEC_READ && s_r.dec != DEC_REPLY && s_r.txBits == 4'h0
        && !(s_r.dec == DEC_PAR1 && s_r.cmd == CMD_QUERY && isLink(s_r.rxByte))
        && !s_r.ackPend |=> s_r.ackPend ##1 s_r.txBits == ACK_FRAME_BITS && linkOut;
    endproperty
    a_ack: assert property (p_ack) else $error("byte not acknowledged");

    property p_par2_cmd;
        @(posedge clock) disable iff (!rst_n)
        s_r.dec == DEC_PAR2 |-> s_r.cmd == CMD_CONNECT || s_r.cmd == CMD_JOIN;
    endproperty
    a_par2_cmd: assert property (p_par2_cmd) else $error("bad parameter count");

    c_join: cover property (@(posedge clock) disable iff (!rst_n)
        s_r.dec == DEC_EXEC);
    c_reply: cover property (@(posedge clock) disable iff (!rst_n) replyGo);
    c_soft: cover property (@(posedge clock) disable iff (!rst_n) s_r.clearAll);

endmodule : lscd_decoder

// >>> tb/lscd_ctrl_model.sv
// Purpose: behavioural controller on the far end of the configuration link
// Assumes: link bit time of BIT_CYCLES clocks, same clock as the decoder
// Notes: the bench queues bytes in txQ; reply bytes are collected in rxQ
`timescale 1ns/1ps
module lscd_ctrl_model (
    // clock
    input wire logic clock,
    // link wires
    output logic toDev,
    input wire logic fromDev
);
    import lscd_pkg::*;

    // ****************************************************************
    // state seen by the bench
    // ****************************************************************
    logic [7:0] txQ[$];
    logic [7:0] rxQ[$];
    logic [7:0] rxByte;
    logic ackDue = 1'b0;
    int sentCount = 0;
    int ackSeen = 0;
    int frameErr = 0;
    // extra cycles before acking a reply, to play a slow controller
    int replyDelay = 0;

    initial toDev = 1'b0;

    task automatic send_frame(input logic [10:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            toDev <= bits[i];
            repeat (BIT_CYCLES) @(posedge clock);
        end
        toDev <= 1'b0;
    endtask : send_frame

    // ****************************************************************
    // transmitter
    // ****************************************************************
    always begin
        @(posedge clock);
        if (ackDue) begin
            repeat (replyDelay) @(posedge clock);
            ackDue = 1'b0;
            send_frame(11'h001, 2);
        end else if (txQ.size() > 0 && ackSeen == sentCount) begin
            sentCount++;
            send_frame({1'b0, txQ.pop_front(), 2'b11}, 11);
        end
    end

    // ****************************************************************
    // receiver: runs apart from the transmitter, the link is full duplex
    // ****************************************************************
    always begin
        @(posedge clock);
        if (fromDev === 1'b1) begin
            repeat (BIT_CYCLES + 1) @(posedge clock);
            if (fromDev === 1'b1) begin
                for (int i = 0; i < 8; i++) begin
                    repeat (BIT_CYCLES) @(posedge clock);
                    rxByte[i] = fromDev;
                end
                repeat (BIT_CYCLES) @(posedge clock);
                if (fromDev !== 1'b0) frameErr++;
                rxQ.push_back(rxByte);
                ackDue = 1'b1;
            end else begin
                if (fromDev !== 1'b0) frameErr++;
                ackSeen++;
                repeat (1) @(posedge clock);
            end
        end
    end
endmodule : lscd_ctrl_model

// >>> tb/lscd_decoder_tb.sv
// Purpose: self-checking bench of the link switch configuration decoder
// Assumes: 40 MHz clock, controller model on the configuration link
// Notes: route lookups are compared two clocks after the address is set
`timescale 1ns/1ps
module lscd_decoder_tb;
    import lscd_pkg::*;

    // ****************************************************************
    // signals
    // ****************************************************************
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [LINK_W-1:0] xbarOutSel = '0;
    logic linkIn;
    logic linkOut;
    logic [LINK_W-1:0] xbarInSel;
    logic xbarConnected;
    logic xbarActive;
    int errTotal = 0;
    int checked = 0;

    always #12.5 clock = ~clock;

    lscd_ctrl_model ctrl (.clock(clock), .toDev(linkIn), .fromDev(linkOut));

    lscd_decoder dut (
        .clock(clock),
        .rst_n(rst_n),
        .linkIn(linkIn),
        .linkOut(linkOut),
        .xbarOutSel(xbarOutSel),
        .xbarInSel(xbarInSel),
        .xbarConnected(xbarConnected),
        .xbarActive(xbarActive)
    );

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] expVal, input string what);
        checked++;
        if (seen !== expVal) begin
            errTotal++;
            $display("BAD %0t %s: seen %h expected %h", $time, what, seen, expVal);
        end
    endtask : check

    task automatic finishTest;
        $display("checks %0d mismatches %0d", checked, errTotal);
        if (errTotal == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finishTest

    task automatic send3(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c, input int n);
        ctrl.txQ.push_back(a);
        if (n > 1) ctrl.txQ.push_back(b);
        if (n > 2) ctrl.txQ.push_back(c);
    endtask : send3

    // waits until every byte is sent, acked, and any reply acked back
    task automatic wait_idle;
        int n;
        n = 0;
        while ((ctrl.txQ.size() > 0 || ctrl.ackSeen != ctrl.sentCount || ctrl.ackDue)
               && n < 4000) begin
            @(posedge clock);
            n++;
        end
        repeat (4 * BIT_CYCLES) @(posedge clock);
        @(negedge clock);
        check(8'(n < 4000), 8'h01, "ack wait");
        check({7'h00, linkOut}, 8'h00, "link idle");
    endtask : wait_idle

    task automatic lookup(input logic [4:0] outNum, input logic [4:0] expIn,
                          input logic expConn, input logic expAct);
        @(posedge clock);
        xbarOutSel <= outNum;
        repeat (2) @(posedge clock);
        @(negedge clock);
        check({6'h00, xbarConnected, xbarActive}, {6'h00, expConn, expAct}, "route state");
        if (expConn) check({3'h0, xbarInSel}, {3'h0, expIn}, "route input");
    endtask : lookup

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_soft_reset;
        send3(CMD_SOFTRST, 8'h00, 8'h00, 1);
        wait_idle();
        for (int o = 0; o < NUM_LINKS; o++) lookup(5'(o), 5'h00, 1'b0, 1'b0);
        $display("test soft reset done");
    endtask : t_soft_reset

    task automatic t_connect;
        send3(CMD_CONNECT, 8'h03, 8'h07, 3);
        wait_idle();
        lookup(5'h07, 5'h03, 1'b1, 1'b0);
        send3(CMD_COMMIT, 8'h00, 8'h00, 1);
        wait_idle();
        lookup(5'h07, 5'h03, 1'b1, 1'b1);
        lookup(5'h03, 5'h00, 1'b0, 1'b0);
        $display("test connect done");
    endtask : t_connect

    task automatic t_join;
        send3(CMD_JOIN, 8'h05, 8'h09, 3);
        wait_idle();
        lookup(5'h09, 5'h05, 1'b1, 1'b0);
        lookup(5'h05, 5'h09, 1'b1, 1'b0);
        send3(CMD_COMMIT, 8'h00, 8'h00, 1);
        wait_idle();
        lookup(5'h09, 5'h05, 1'b1, 1'b1);
        lookup(5'h05, 5'h09, 1'b1, 1'b1);
        lookup(5'h07, 5'h03, 1'b1, 1'b1);
        $display("test join done");
    endtask : t_join

    task automatic t_query;
        send3(CMD_QUERY, 8'h07, 8'h00, 2);
        wait_idle();
        check(8'(ctrl.rxQ.size()), 8'h01, "reply count");
        if (ctrl.rxQ.size() > 0) check(ctrl.rxQ.pop_front(), 8'h03, "reply value");
        ctrl.replyDelay = 20;
        send3(CMD_QUERY, 8'h14, 8'h00, 2);
        send3(CMD_QUERY, 8'h05, 8'h00, 2);
        wait_idle();
        ctrl.replyDelay = 0;
        check(8'(ctrl.rxQ.size()), 8'h02, "reply count");
        if (ctrl.rxQ.size() > 0) check(ctrl.rxQ.pop_front(), NO_INPUT, "unrouted");
        if (ctrl.rxQ.size() > 0) check(ctrl.rxQ.pop_front(), 8'h09, "reply value");
        $display("test query done");
    endtask : t_query

    task automatic t_hw_reset;
        @(posedge clock);
        rst_n <= 1'b0;
        @(negedge clock);
        check({7'h00, linkOut}, 8'h00, "link in reset");
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        lookup(5'h07, 5'h03, 1'b1, 1'b1);
        lookup(5'h09, 5'h05, 1'b1, 1'b1);
        $display("test hardware reset done");
    endtask : t_hw_reset

    task automatic t_abort;
        // unknown code, then a connect with an out-of-range input
        send3(8'h09, CMD_CONNECT, 8'h28, 3);
        send3(CMD_CONNECT, 8'h02, 8'h04, 3);
        wait_idle();
        check(8'(ctrl.sentCount - ctrl.ackSeen), 8'h00, "acks");
        lookup(5'h04, 5'h02, 1'b1, 1'b0);
        send3(CMD_SOFTRST, 8'h00, 8'h00, 1);
        wait_idle();
        lookup(5'h04, 5'h00, 1'b0, 1'b0);
        lookup(5'h07, 5'h00, 1'b0, 1'b0);
        check(8'(ctrl.frameErr), 8'h00, "frame errors");
        $display("test abort done");
    endtask : t_abort

    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    initial begin
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        t_soft_reset();
        t_connect();
        t_join();
        t_query();
        t_hw_reset();
        t_abort();
        finishTest();
    end

    // the whole run needs about 2000 clocks
    initial begin
        repeat (30000) @(posedge clock);
        errTotal++;
        $display("BAD %0t watchdog expired", $time);
        finishTest();
    end
endmodule : lscd_decoder_tb
